// [dv/acs_ctrl_tb_top.sv]
// Self-checking bench for the gain order and carrier sense register
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_tb_top;
  import acs_pkg::*;
  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  logic [5:0] addr  = 6'h00;
  logic       wr    = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [2:0] goal  = 3'h3;
  logic       req   = 1'b0;
  logic [2:0] lna   = 3'h0;
  logic [2:0] lna2  = 3'h0;
  logic       dec1;
  logic       dec2;
  logic       valid = 1'b0;
  logic [7:0] rssi  = 8'h00;
  logic       cs;
  int         error_cnt   = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  int         gdb[8]      = '{24, 27, 30, 33, 36, 38, 40, 42};
  int         rise[4]     = '{0, 6, 10, 14};

  acs_ctrl i_dut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .amplitude_goal_in(goal), .gain_down_req_in(req),
    .lna_gain_in(lna), .lna2_gain_in(lna2), .lna_dec_out(dec1), .lna2_dec_out(dec2),
    .rssi_valid_in(valid), .rssi_in(rssi), .carrier_sense_out(cs));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("Counts: comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    chk(rdata, e, "readback");
  endtask

  task automatic gdn(input logic [2:0] l1, input logic [2:0] l2, input logic e1, input logic e2);
    @(posedge clk);
    req <= 1'b1;
    lna <= l1;
    lna2 <= l2;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk({6'h00, dec1, dec2}, {6'h00, e1, e2}, "gain step");
  endtask

  task automatic samp(input int r, input logic e);
    @(posedge clk);
    valid <= 1'b1;
    rssi <= 8'(r);
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    chk({7'h00, cs}, {7'h00, e}, "carrier sense");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rreg(ACS_CTRL_ADDR, 8'h40);
    wreg(6'h1d, 8'hff);
    rreg(6'h1d, 8'h00);
    rreg(ACS_CTRL_ADDR, 8'h40);
    wreg(ACS_CTRL_ADDR, 8'hff);
    rreg(ACS_CTRL_ADDR, 8'h7f);
    $display("Test registers done");
    wreg(ACS_CTRL_ADDR, 8'h40);
    gdn(3'h3, 3'h2, 1'b1, 1'b0);
    gdn(3'h0, 3'h2, 1'b0, 1'b1);
    wreg(ACS_CTRL_ADDR, 8'h00);
    gdn(3'h3, 3'h2, 1'b0, 1'b1);
    gdn(3'h3, 3'h0, 1'b1, 1'b0);
    gdn(3'h0, 3'h0, 1'b0, 1'b0);
    $display("Test gain order done");
    wreg(ACS_CTRL_ADDR, 8'h40);
    for (int g = 0; g < 8; g++) begin
      @(posedge clk);
      goal <= 3'(g);
      samp(gdb[g] - 1, 1'b0);
      samp(gdb[g], 1'b1);
    end
    @(posedge clk);
    goal <= 3'h3;
    for (int t = -7; t < 8; t++) begin
      wreg(ACS_CTRL_ADDR, 8'h40 | 8'(t & 15));
      samp(33 + t - 1, 1'b0);
      samp(33 + t, 1'b1);
    end
    wreg(ACS_CTRL_ADDR, 8'h48);
    samp(255, 1'b0);
    $display("Test level threshold done");
    // Base sample of zero resets the rise reference between codes
    for (int c = 1; c < 4; c++) begin
      wreg(ACS_CTRL_ADDR, 8'h48 | 8'(c << 4));
      samp(0, 1'b0);
      samp(rise[c], 1'b1);
      samp(0, 1'b0);
      samp(rise[c] - 1, 1'b0);
    end
    wreg(ACS_CTRL_ADDR, 8'h48);
    samp(0, 1'b0);
    samp(255, 1'b0);
    $display("Test rise threshold done");
    complete_run;
  end
endmodule
`default_nettype wire

// [rtl/acs_ctrl.sv]
// Gain reduction order and carrier sense control register with its decision logic
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl
  import acs_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [5:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [2:0] amplitude_goal_in,
  input  wire logic       gain_down_req_in,
  input  wire logic [2:0] lna_gain_in,
  input  wire logic [2:0] lna2_gain_in,
  output logic            lna_dec_out,
  output logic            lna2_dec_out,
  input  wire logic       rssi_valid_in,
  input  wire logic [7:0] rssi_in,
  output logic            carrier_sense_out
);
  logic       gain_reduce_order_select_reg;
  logic [1:0] cs_rise_threshold_reg;
  logic [3:0] cs_level_threshold_reg;
  logic [7:0] rssi_ref_reg;
  logic       ref_valid_reg;
  logic       level_hit;
  logic       rise_hit;
  logic       wr_hit;

  assign wr_hit = reg_wr_in && (reg_addr_in == ACS_CTRL_ADDR);

  // One block per field; bit 7 has no storage, so writes to it vanish
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gain_reduce_order_select_reg <= ACS_ORDER_RESET;
    end else if (wr_hit) begin
      gain_reduce_order_select_reg <= reg_wdata_in[ACS_ORDER_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cs_rise_threshold_reg <= ACS_RISE_RESET;
    end else if (wr_hit) begin
      cs_rise_threshold_reg <= reg_wdata_in[ACS_RISE_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cs_level_threshold_reg <= ACS_LEVEL_RESET;
    end else if (wr_hit) begin
      cs_level_threshold_reg <= reg_wdata_in[ACS_LEVEL_LSB +: 4];
    end
  end

  // Readback is combinational so a read sees the last write at once
  always_comb begin
    reg_rdata_out = 8'h00;
    if (reg_addr_in == ACS_CTRL_ADDR) begin
      reg_rdata_out = {1'b0, gain_reduce_order_select_reg, cs_rise_threshold_reg, cs_level_threshold_reg};
    end
  end

  // One-cycle decrement pulses; a stage at minimum passes the step on
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lna_dec_out  <= 1'b0;
      lna2_dec_out <= 1'b0;
    end else begin
      lna_dec_out  <= 1'b0;
      lna2_dec_out <= 1'b0;
      if (gain_down_req_in) begin
        if (gain_reduce_order_select_reg) begin
          if (lna_gain_in != ACS_GAIN_MIN) begin
            lna_dec_out <= 1'b1;
          end else if (lna2_gain_in != ACS_GAIN_MIN) begin
            lna2_dec_out <= 1'b1;
          end
        end else begin
          if (lna2_gain_in != ACS_GAIN_MIN) begin
            lna2_dec_out <= 1'b1;
          end else if (lna_gain_in != ACS_GAIN_MIN) begin
            lna_dec_out <= 1'b1;
          end
        end
      end
    end
  end

  assign level_hit = (cs_level_threshold_reg != ACS_LEVEL_OFF) &&
                     ({1'b0, rssi_in} >= acs_level_db(amplitude_goal_in, cs_level_threshold_reg));
  assign rise_hit  = (cs_rise_threshold_reg != ACS_RISE_OFF) && ref_valid_reg &&
                     ({1'b0, rssi_in} >= 9'({1'b0, rssi_ref_reg} + acs_rise_db(cs_rise_threshold_reg)));

  // Reference follows the signal while carrier sense is low, so a rise is measured from the quiet level
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rssi_ref_reg  <= 8'h00;
      ref_valid_reg <= 1'b0;
    end else if (rssi_valid_in && !(level_hit || rise_hit)) begin
      rssi_ref_reg  <= rssi_in;
      ref_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      carrier_sense_out <= 1'b0;
    end else if (rssi_valid_in) begin
      carrier_sense_out <= level_hit || rise_hit;
    end
  end

  logic [8:0] lvl_chk;
  assign lvl_chk = acs_level_db(amplitude_goal_in, cs_level_threshold_reg);

  order_lna_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    gain_down_req_in && gain_reduce_order_select_reg && lna_gain_in != 3'h0 |=> lna_dec_out && !lna2_dec_out)
    else $error("First stage not lowered first");
  order_lna2_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    gain_down_req_in && !gain_reduce_order_select_reg && lna2_gain_in != 3'h0 |=> lna2_dec_out && !lna_dec_out)
    else $error("Second stage not lowered first");
  order_fall_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    gain_down_req_in && !gain_reduce_order_select_reg && lna2_gain_in == 3'h0 && lna_gain_in != 3'h0
    |=> lna_dec_out)
    else $error("First stage not lowered after second at minimum");
  rise_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && cs_rise_threshold_reg == 2'h0 && !level_hit |=> !carrier_sense_out)
    else $error("Rise criterion active while disabled");
  rise_six_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && ref_valid_reg && cs_rise_threshold_reg == 2'h1 && {1'b0, rssi_in} >= {1'b0, rssi_ref_reg} + 9'd6
    |=> carrier_sense_out)
    else $error("6 dB rise missed");
  level_sign_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cs_level_threshold_reg == 4'hf |-> lvl_chk == acs_goal_db(amplitude_goal_in) - 9'd1)
    else $error("Level offset sign wrong");
  level_hit_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && cs_level_threshold_reg == 4'h7 && amplitude_goal_in == ACS_GOAL_RESET && rssi_in >= 8'd40
    |=> carrier_sense_out)
    else $error("Level threshold reached but no carrier sense");
  level_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && cs_level_threshold_reg == 4'h8 && cs_rise_threshold_reg == 2'h0 |=> !carrier_sense_out)
    else $error("Level criterion active while disabled");
  goal_top_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    amplitude_goal_in == 3'h7 && cs_level_threshold_reg == 4'h0 |-> lvl_chk == 9'd42)
    else $error("Goal code 111 not 42 dB");
  bit7_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_hit ##1 reg_addr_in == ACS_CTRL_ADDR
    |-> reg_rdata_out == ($past(reg_wdata_in) & 8'h7f))
    else $error("Readback differs from written value with bit 7 cleared");
  unmapped_rd_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    reg_addr_in != ACS_CTRL_ADDR |-> reg_rdata_out == 8'h00)
    else $error("Unmapped address reads nonzero");
  unmapped_wr_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in != ACS_CTRL_ADDR
    |=> $stable(gain_reduce_order_select_reg) && $stable(cs_rise_threshold_reg)
        && $stable(cs_level_threshold_reg))
    else $error("Write to unmapped address changed the register");

  // Reset checks carry no disable so the reset itself is watched
  reset_regs_a: assert property (@(posedge core_clk_in)
    rst_in |=> gain_reduce_order_select_reg == ACS_ORDER_RESET && cs_rise_threshold_reg == ACS_RISE_RESET
               && cs_level_threshold_reg == ACS_LEVEL_RESET)
    else $error("Register not at reset value");
  reset_outs_a: assert property (@(posedge core_clk_in)
    rst_in |=> !carrier_sense_out && !ref_valid_reg && !lna_dec_out && !lna2_dec_out)
    else $error("Outputs not idle after reset");

  dec_onehot_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(lna_dec_out && lna2_dec_out))
    else $error("Both stages lowered in one step");
  no_req_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !gain_down_req_in |=> !lna_dec_out && !lna2_dec_out)
    else $error("Gain step without request");
  both_min_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    gain_down_req_in && lna_gain_in == ACS_GAIN_MIN && lna2_gain_in == ACS_GAIN_MIN
    |=> !lna_dec_out && !lna2_dec_out)
    else $error("Gain step with both stages at minimum");
  order_spill_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    gain_down_req_in && gain_reduce_order_select_reg && lna_gain_in == ACS_GAIN_MIN && lna2_gain_in != ACS_GAIN_MIN
    |=> lna2_dec_out && !lna_dec_out)
    else $error("Second stage not lowered with first at minimum");

  rise_ten_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && ref_valid_reg && cs_rise_threshold_reg == 2'h2
    && {1'b0, rssi_in} >= {1'b0, rssi_ref_reg} + 9'h00a |=> carrier_sense_out)
    else $error("10 dB rise missed");
  rise_ftn_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && ref_valid_reg && cs_rise_threshold_reg == 2'h3
    && {1'b0, rssi_in} >= {1'b0, rssi_ref_reg} + 9'h00e |=> carrier_sense_out)
    else $error("14 dB rise missed");
  ref_frozen_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && (level_hit || rise_hit) |=> $stable(rssi_ref_reg))
    else $error("Rise reference moved while sensing");
  ref_track_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && !(level_hit || rise_hit) |=> ref_valid_reg && rssi_ref_reg == $past(rssi_in))
    else $error("Rise reference not following quiet level");
  level_below_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rssi_valid_in && cs_level_threshold_reg != ACS_LEVEL_OFF && cs_rise_threshold_reg == ACS_RISE_OFF
    && {1'b0, rssi_in} < lvl_chk |=> !carrier_sense_out)
    else $error("Carrier sense below the level threshold");
  level_neg7_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    amplitude_goal_in == ACS_GOAL_RESET && cs_level_threshold_reg == 4'h9 |-> lvl_chk == 9'h01a)
    else $error("Code 1001 not 7 dB below goal");
  level_pos7_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    amplitude_goal_in == ACS_GOAL_RESET && cs_level_threshold_reg == 4'h7 |-> lvl_chk == 9'h028)
    else $error("Code 0111 not 7 dB above goal");
  goal_base_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    amplitude_goal_in == 3'h0 && cs_level_threshold_reg == 4'h0 |-> lvl_chk == 9'h018)
    else $error("Goal code 000 not 24 dB");
  cs_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !rssi_valid_in |=> $stable(carrier_sense_out))
    else $error("Carrier sense changed without a sample");

  sense_rise_c: cover property (@(posedge core_clk_in) disable iff (rst_in) rise_hit && rssi_valid_in);
  sense_level_c: cover property (@(posedge core_clk_in) disable iff (rst_in) level_hit && rssi_valid_in);
  lna2_first_c: cover property (@(posedge core_clk_in) disable iff (rst_in) lna2_dec_out ##[1:3] lna_dec_out);
  order_spill_c: cover property (@(posedge core_clk_in) disable iff (rst_in) gain_reduce_order_select_reg && lna2_dec_out);
  sense_drop_c: cover property (@(posedge core_clk_in) disable iff (rst_in) carrier_sense_out ##1 !carrier_sense_out);
endmodule
`default_nettype wire

// [rtl/acs_pkg.sv]
// Constants and helpers for the gain order and carrier sense register bank
// What this block does
// - With the order select bit at 1, a gain reduction request lowers the first-stage amplifier gain first.
// - With the order select bit at 0, the second-stage gain is taken to its minimum before the first stage is lowered.
// - The rise threshold field in bits 5:4 disables the rise criterion when it holds 00, its reset value.
// - Rise codes 01, 10 and 11 raise carrier sense on a signal strength rise of 6, 10 or 14 dB.
// - The level threshold field in bits 3:0 is a signed two's complement offset in 1 dB steps from the amplitude goal.
// - Carrier sense is raised when signal strength reaches the level threshold; codes 1001 to 0111 mean -7 to +7 dB.
// - The level threshold code 1000 disables the level criterion.
// - Amplitude goal codes 000 to 111 mean 24, 27, 30, 33, 36, 38, 40 and 42 dB, with 011 after reset.
package acs_pkg;
  localparam logic [5:0] ACS_CTRL_ADDR    = 6'h1c;
  localparam int         ACS_ORDER_BIT    = 6;
  localparam int         ACS_RISE_LSB     = 4;
  localparam int         ACS_LEVEL_LSB    = 0;
  localparam logic       ACS_ORDER_RESET  = 1'b1;
  localparam logic [1:0] ACS_RISE_RESET   = 2'h0;
  localparam logic [3:0] ACS_LEVEL_RESET  = 4'h0;
  localparam logic [3:0] ACS_LEVEL_OFF    = 4'h8;
  localparam logic [1:0] ACS_RISE_OFF     = 2'h0;
  localparam logic [2:0] ACS_GOAL_RESET   = 3'h3;
  localparam logic [2:0] ACS_GAIN_MIN     = 3'h0;
  localparam logic [8:0] ACS_RISE_6DB     = 9'h006;
  localparam logic [8:0] ACS_RISE_10DB    = 9'h00a;
  localparam logic [8:0] ACS_RISE_14DB    = 9'h00e;

  // Amplitude goal in dB
  function automatic logic [8:0] acs_goal_db(input logic [2:0] code);
    case (code)
      3'h0:    acs_goal_db = 9'h018;
      3'h1:    acs_goal_db = 9'h01b;
      3'h2:    acs_goal_db = 9'h01e;
      3'h3:    acs_goal_db = 9'h021;
      3'h4:    acs_goal_db = 9'h024;
      3'h5:    acs_goal_db = 9'h026;
      3'h6:    acs_goal_db = 9'h028;
      default: acs_goal_db = 9'h02a;
    endcase
  endfunction

  function automatic logic [8:0] acs_rise_db(input logic [1:0] code);
    case (code)
      2'h1:    acs_rise_db = ACS_RISE_6DB;
      2'h2:    acs_rise_db = ACS_RISE_10DB;
      default: acs_rise_db = ACS_RISE_14DB;
    endcase
  endfunction

  // Goal plus signed offset; goal is at least 24 so the sum stays positive
  function automatic logic [8:0] acs_level_db(input logic [2:0] goal, input logic [3:0] thr);
    acs_level_db = 9'(acs_goal_db(goal) + {{5{thr[3]}}, thr});
  endfunction
endpackage
